// file: logic/cmu_pkg.sv
package cmu_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'hEB;
  localparam logic [7:0] IDX_CTRL = 8'hF0;
  localparam logic [7:0] IDX_FLAG = 8'hF2;
  localparam logic [7:0] IDX_PLL = 8'hF6;
  localparam int ADR_W = 10;

  // reset values
  localparam logic [7:0] RST_MODE = 8'hE0;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'h08;
  localparam logic [7:0] RST_PLL = 8'h07;

  // mode_clock_divide fields
  localparam int MODE_HALVE = 5;
  localparam int MODE_PRS_LO = 2;
  localparam int PRS_W = 3;
  // clock_control fields
  localparam int CTRL_INT_SEL = 7;
  localparam int CTRL_HALT_RST = 3;
  localparam int CTRL_AUX_SEL = 2;
  localparam int CTRL_WAIT_SEL = 1;
  localparam int CTRL_LP_EN = 0;
  // clock_flags fields
  localparam int FLAG_EXT_STOP = 7;
  localparam int FLAG_XTAL_STOP = 4;
  localparam int FLAG_SLOW16 = 3;
  localparam int FLAG_AUX_ACT = 2;
  localparam int FLAG_PLL_SEL = 0;
  // pll_config fields
  localparam int PLL_MX_LO = 4;
  localparam int MX_W = 2;
  localparam int PLL_DX_LO = 0;
  localparam int DX_W = 3;
  localparam logic [DX_W-1:0] DX_OFF = 3'h7;

  // multiplier factor per field code
  localparam logic [3:0] MULT_14 = 4'hE;
  localparam logic [3:0] MULT_10 = 4'hA;
  localparam logic [3:0] MULT_8 = 4'h8;
  localparam logic [3:0] MULT_6 = 4'h6;
  localparam logic [1:0] MX_CODE_14 = 2'h2;
  localparam logic [1:0] MX_CODE_10 = 2'h0;
  localparam logic [1:0] MX_CODE_8 = 2'h3;

  localparam int SLOW_W = 4;
  localparam int PIN_N = 4;
  localparam int PIN_OSC = 0;
  localparam int PIN_PLL = 1;
  localparam int PIN_AUX = 2;
  localparam int PIN_STOP = 3;

  typedef enum logic [1:0] {SEL_REF, SEL_SLOW16, SEL_PLL, SEL_AUX} cmu_sel_t;

  // candidate system clock levels, all in the clk_i domain
  typedef struct packed {
    logic aux;
    logic pll;
    logic slow;
    logic ref_clk;
  } cmu_src_t;
endpackage

// file: logic/cmu_top.sv
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module cmu_top #(
  parameter int AUX_TIMEOUT_CYC = 64,
  parameter int IRQ_LOW_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cmu_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_clk_i,
  input wire logic pll_clk_i,
  input wire logic aux_clk_i,
  input wire logic hw_stop_i,
  input wire logic wfi_i,
  input wire logic mem_wait_i,
  input wire logic bus_req_i,
  output logic sys_clk_o,
  output logic periph_clk_o,
  output logic cpu_clk_o,
  output logic osc_enable_o,
  output logic pll_power_o,
  output logic [3:0] pll_mult_o,
  output logic halt_reset_en_o,
  output logic irq_n_o
);
  import cmu_pkg::*;

  localparam int TO_W = $clog2(AUX_TIMEOUT_CYC + 1);
  localparam int IRQ_W = $clog2(IRQ_LOW_CYC + 1);
  localparam logic [TO_W-1:0] TO_MAX = TO_W'(AUX_TIMEOUT_CYC);
  localparam logic [IRQ_W-1:0] IRQ_MAX = IRQ_W'(IRQ_LOW_CYC);

  if (AUX_TIMEOUT_CYC < 2 || IRQ_LOW_CYC < 1) begin : g_chk
    $error("cmu_top: AUX_TIMEOUT_CYC >= 2 and IRQ_LOW_CYC >= 1 required");
  end

  // pin synchronisers: three stages, level moves when stages 2 and 3 agree
  logic [PIN_N-1:0] pins;
  wire logic [PIN_N-1:0] pin_lvl_q;
  assign pins = {hw_stop_i, aux_clk_i, pll_clk_i, osc_clk_i};
  for (genvar i = 0; i < PIN_N; i++) begin : g_sync
    logic s1_q, s2_q, s3_q, lvl_q;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        lvl_q <= 1'b0;
      end else begin
        s1_q <= pins[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end
    end
    assign pin_lvl_q[i] = lvl_q;
  end

  logic [PIN_N-1:0] pin_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) pin_prev_q <= '0;
    else pin_prev_q <= pin_lvl_q;
  end
  logic osc_rise, pll_rise, aux_rise, stop_rise, stop_fall;
  assign osc_rise = pin_lvl_q[PIN_OSC] & ~pin_prev_q[PIN_OSC];
  assign pll_rise = pin_lvl_q[PIN_PLL] & ~pin_prev_q[PIN_PLL];
  assign aux_rise = pin_lvl_q[PIN_AUX] & ~pin_prev_q[PIN_AUX];
  assign stop_rise = pin_lvl_q[PIN_STOP] & ~pin_prev_q[PIN_STOP];
  assign stop_fall = ~pin_lvl_q[PIN_STOP] & pin_prev_q[PIN_STOP];

  // register storage
  logic [7:0] mode_q, ctrl_q, pll_cfg_q;
  logic ext_stop_q, xtal_stop_q, slow16_q, pll_sel_q;
  logic aux_sel_q;
  logic wb_ack_q;
  logic [31:0] wb_dat_q;
  logic bus_req, wr_en;
  logic [7:0] wr_byte, idx;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];
  assign idx = wb_adr_i[ADR_W-1:2];

  logic input_halve, lp_en, wait_sel, int_sel;
  logic [PRS_W-1:0] prs_field;
  logic [DX_W-1:0] dx_field;
  logic [MX_W-1:0] mx_field;
  assign input_halve = mode_q[MODE_HALVE];
  assign prs_field = mode_q[MODE_PRS_LO +: PRS_W];
  assign lp_en = ctrl_q[CTRL_LP_EN];
  assign wait_sel = ctrl_q[CTRL_WAIT_SEL];
  assign int_sel = ctrl_q[CTRL_INT_SEL];
  assign dx_field = pll_cfg_q[PLL_DX_LO +: DX_W];
  assign mx_field = pll_cfg_q[PLL_MX_LO +: MX_W];

  logic wfi_q, wfi_rise, lp_active;
  always_ff @(posedge clk_i) begin
    if (rst_i) wfi_q <= 1'b0;
    else wfi_q <= wfi_i;
  end
  assign wfi_rise = wfi_i & ~wfi_q;
  assign lp_active = wfi_i & lp_en;

  logic aux_present, aux_active;
  logic osc_en_q, xtal_off;
  cmu_sel_t sel_q, want_sel;

  assign aux_active = (sel_q == SEL_AUX);
  // crystal restarts once aux is deselected; a frozen ref would block the
  // switch back for good
  assign xtal_off = xtal_stop_q & aux_active & aux_sel_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= RST_MODE;
      pll_cfg_q <= RST_PLL;
    end else if (wr_en) begin
      if (idx == IDX_MODE) mode_q <= wr_byte;
      else if (idx == IDX_PLL) begin
        pll_cfg_q <= {2'h0, wr_byte[PLL_MX_LO +: MX_W], 1'b0,
                      wr_byte[PLL_DX_LO +: DX_W]};
      end
    end
  end

  // control register; low power wait entry with wait_sel forces aux select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= RST_CTRL;
      aux_sel_q <= 1'b0;
    end else begin
      if (wr_en && idx == IDX_CTRL) begin
        ctrl_q <= {wr_byte[CTRL_INT_SEL], 3'h0,
                   wr_byte[CTRL_HALT_RST:CTRL_LP_EN]};
        aux_sel_q <= wr_byte[CTRL_AUX_SEL];
      end
      if (wfi_rise && lp_en && wait_sel) aux_sel_q <= 1'b1;
    end
  end

  logic flag_wr;
  assign flag_wr = wr_en && idx == IDX_FLAG;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_stop_q <= 1'b0;
      xtal_stop_q <= 1'b0;
      slow16_q <= RST_FLAG[FLAG_SLOW16];
    end else begin
      if (flag_wr) begin
        xtal_stop_q <= wr_byte[FLAG_XTAL_STOP];
        slow16_q <= wr_byte[FLAG_SLOW16];
        if (!wr_byte[FLAG_EXT_STOP]) ext_stop_q <= 1'b0;
      end
      // hardware set wins over a software clear in the same cycle
      if (stop_rise) ext_stop_q <= 1'b1;
      if (wfi_rise && wait_sel) xtal_stop_q <= 1'b1;
    end
  end

  // pll_select: hardware clears win, they protect against an unlocked pll
  logic pll_sel_clr;
  assign pll_sel_clr = (wr_en && idx == IDX_PLL
                        && wr_byte[PLL_DX_LO +: DX_W] == DX_OFF)
                     || (flag_wr && !wr_byte[FLAG_SLOW16])
                     || (osc_en_q && xtal_off)
                     || (wfi_rise && lp_en);
  always_ff @(posedge clk_i) begin
    if (rst_i) pll_sel_q <= 1'b0;
    else if (pll_sel_clr) pll_sel_q <= 1'b0;
    else if (flag_wr) pll_sel_q <= wr_byte[FLAG_PLL_SEL];
  end

  // crystal enable and pll power, registered outputs
  logic pll_on;
  assign pll_on = (dx_field != DX_OFF) && slow16_q && !lp_active;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_en_q <= 1'b1;
      pll_power_o <= 1'b0;
      pll_mult_o <= MULT_10;
    end else begin
      osc_en_q <= ~xtal_off;
      pll_power_o <= pll_on;
      case (mx_field)
        MX_CODE_14: pll_mult_o <= MULT_14;
        MX_CODE_10: pll_mult_o <= MULT_10;
        MX_CODE_8: pll_mult_o <= MULT_8;
        default: pll_mult_o <= MULT_6;
      endcase
    end
  end
  assign osc_enable_o = osc_en_q;

  // reference clock and its divide by 16
  logic ref_half_q;
  logic [SLOW_W-1:0] slow_cnt_q;
  cmu_src_t src;
  logic ref_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) ref_half_q <= 1'b0;
    else if (osc_rise) ref_half_q <= ~ref_half_q;
  end
  assign src.ref_clk = input_halve ? ref_half_q : pin_lvl_q[PIN_OSC];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_prev_q <= 1'b0;
      slow_cnt_q <= '0;
    end else begin
      ref_prev_q <= src.ref_clk;
      if (src.ref_clk && !ref_prev_q) slow_cnt_q <= slow_cnt_q + 1'b1;
    end
  end
  assign src.slow = slow_cnt_q[SLOW_W-1];

  // pll output divider: high for the first half of field+1 input periods
  logic [DX_W-1:0] pdiv_cnt_q;
  logic pdiv_lvl_q;
  logic [DX_W:0] pdiv_half;
  assign pdiv_half = ({1'b0, dx_field} + 4'h2) >> 1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pdiv_cnt_q <= '0;
      pdiv_lvl_q <= 1'b0;
    end else if (pll_rise) begin
      if (pdiv_cnt_q >= dx_field) begin
        pdiv_cnt_q <= '0;
        pdiv_lvl_q <= 1'b1;
      end else begin
        pdiv_cnt_q <= pdiv_cnt_q + 1'b1;
        pdiv_lvl_q <= ({1'b0, pdiv_cnt_q} + 4'h1) < pdiv_half;
      end
    end
  end
  assign src.pll = (dx_field == '0) ? pin_lvl_q[PIN_PLL] : pdiv_lvl_q;
  assign src.aux = pin_lvl_q[PIN_AUX];

  // aux presence: an edge must arrive within the timeout
  logic [TO_W-1:0] aux_to_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) aux_to_q <= TO_MAX;
    else if (aux_rise) aux_to_q <= '0;
    else if (aux_to_q != TO_MAX) aux_to_q <= aux_to_q + 1'b1;
  end
  assign aux_present = (aux_to_q != TO_MAX);

  // source choice in priority order
  always_comb begin
    if (aux_sel_q && aux_present) want_sel = SEL_AUX;
    else if (!slow16_q || lp_active) want_sel = SEL_SLOW16;
    else if (pll_sel_q && pll_on) want_sel = SEL_PLL;
    else want_sel = SEL_REF;
  end

  function automatic logic lvl_of(cmu_sel_t s, cmu_src_t v);
    case (s)
      SEL_AUX: lvl_of = v.aux;
      SEL_PLL: lvl_of = v.pll;
      SEL_SLOW16: lvl_of = v.slow;
      default: lvl_of = v.ref_clk;
    endcase
  endfunction

  // switch only while both old and new levels are low, so no runt pulse;
  // a dead old source may be left at any level
  logic cur_dead, do_switch, sys_d, sys_q;
  assign cur_dead = (sel_q == SEL_AUX && !aux_present)
                  || (sel_q == SEL_PLL && !pll_on)
                  || (sel_q == SEL_REF && !osc_en_q);
  assign do_switch = (want_sel != sel_q)
                   && (!lvl_of(sel_q, src) || cur_dead)
                   && !lvl_of(want_sel, src)
                   && (want_sel != SEL_AUX || aux_present);
  always_ff @(posedge clk_i) begin
    if (rst_i) sel_q <= SEL_REF;
    else if (do_switch) sel_q <= want_sel;
  end
  assign sys_d = do_switch ? 1'b0 : lvl_of(sel_q, src);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_q <= 1'b0;
      periph_clk_o <= 1'b0;
    end else begin
      sys_q <= sys_d;
      periph_clk_o <= sys_d;
    end
  end
  assign sys_clk_o = sys_q;

  // cpu prescaler; gate changes only at a system rising edge
  logic sys_rise, stall, gate_q, gate_next;
  logic [PRS_W-1:0] prs_cnt_q, prs_next;
  assign sys_rise = sys_d & ~sys_q;
  assign stall = wfi_i | mem_wait_i | bus_req_i;
  assign prs_next = (prs_cnt_q >= prs_field) ? '0 : prs_cnt_q + 1'b1;
  assign gate_next = sys_rise ? ((prs_next != '0) || stall) : gate_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prs_cnt_q <= '0;
      gate_q <= 1'b0;
      cpu_clk_o <= 1'b0;
    end else begin
      if (sys_rise) prs_cnt_q <= prs_next;
      gate_q <= gate_next;
      cpu_clk_o <= sys_d | gate_next;
    end
  end

  // clock change interrupt: a low pulse on irq_n_o
  logic sel_evt, irq_evt;
  logic [IRQ_W-1:0] irq_cnt_q;
  cmu_sel_t sel_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) sel_prev_q <= SEL_REF;
    else sel_prev_q <= sel_q;
  end
  assign sel_evt = ((sel_prev_q == SEL_AUX) != (sel_q == SEL_AUX))
                || ((sel_prev_q == SEL_SLOW16) != (sel_q == SEL_SLOW16));
  assign irq_evt = (sel_evt || stop_fall) && int_sel;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_n_o <= 1'b1;
      irq_cnt_q <= '0;
    end else if (irq_evt) begin
      irq_n_o <= 1'b0;
      irq_cnt_q <= IRQ_MAX;
    end else if (irq_cnt_q > 1) begin
      irq_cnt_q <= irq_cnt_q - 1'b1;
    end else begin
      irq_cnt_q <= '0;
      irq_n_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) halt_reset_en_o <= 1'b0;
    else halt_reset_en_o <= ctrl_q[CTRL_HALT_RST];
  end

  // wishbone classic slave, one wait state, unmapped reads zero
  logic [7:0] rd_byte, flag_rd;
  always_comb begin
    flag_rd = 8'h00;
    flag_rd[FLAG_EXT_STOP] = ext_stop_q;
    flag_rd[FLAG_XTAL_STOP] = xtal_stop_q & aux_active;
    flag_rd[FLAG_SLOW16] = slow16_q;
    flag_rd[FLAG_AUX_ACT] = aux_active;
    flag_rd[FLAG_PLL_SEL] = pll_sel_q;
    if (idx == IDX_MODE) rd_byte = mode_q;
    else if (idx == IDX_CTRL) begin
      rd_byte = ctrl_q;
      rd_byte[CTRL_AUX_SEL] = aux_sel_q;
    end else if (idx == IDX_FLAG) rd_byte = flag_rd;
    else if (idx == IDX_PLL) rd_byte = pll_cfg_q;
    else rd_byte = 8'h00;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= '0;
    end else begin
      wb_ack_q <= bus_req;
      wb_dat_q <= bus_req ? {24'h000000, rd_byte} : '0;
    end
  end
  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  property p_wb_ack;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_q) |=> wb_ack_q;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("no ack");

  property p_halve;
    @(posedge clk_i) disable iff (rst_i)
    osc_rise |=> (ref_half_q != $past(ref_half_q));
  endproperty
  a_halve: assert property (p_halve) else $error("halver stuck");

  property p_pll_off;
    @(posedge clk_i) disable iff (rst_i)
    (dx_field == DX_OFF) |=> !pll_power_o;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll on");

  property p_sel_clr;
    @(posedge clk_i) disable iff (rst_i)
    pll_sel_clr |=> !pll_sel_q;
  endproperty
  a_sel_clr: assert property (p_sel_clr) else $error("pll sel");

  sequence s_no_div;
    (prs_field == '0 && !stall && !gate_q) [*2];
  endsequence
  property p_cpu_eq;
    @(posedge clk_i) disable iff (rst_i)
    s_no_div |=> (cpu_clk_o == sys_q);
  endproperty
  a_cpu_eq: assert property (p_cpu_eq) else $error("cpu phase");

  property p_stall;
    @(posedge clk_i) disable iff (rst_i)
    (gate_q && stall) |=> cpu_clk_o;
  endproperty
  a_stall: assert property (p_stall) else $error("cpu not held");

  property p_xtal;
    @(posedge clk_i) disable iff (rst_i)
    !osc_en_q |-> $past(xtal_stop_q && aux_active);
  endproperty
  a_xtal: assert property (p_xtal) else $error("xtal stop");

  property p_aux_ok;
    @(posedge clk_i) disable iff (rst_i)
    ($changed(sel_q) && sel_q == SEL_AUX) |-> $past(aux_present);
  endproperty
  a_aux_ok: assert property (p_aux_ok) else $error("aux absent");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    irq_evt |=> !irq_n_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_irq_mask;
    @(posedge clk_i) disable iff (rst_i)
    (!int_sel && irq_n_o) |=> irq_n_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq mask");

  property p_slow;
    @(posedge clk_i) disable iff (rst_i)
    (!slow16_q && !aux_sel_q) |-> (want_sel == SEL_SLOW16);
  endproperty
  a_slow: assert property (p_slow) else $error("slow16");
endmodule
`default_nettype wire

// file: verif/cmu_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module cmu_src_model (
  input wire logic clk_i,
  input wire logic osc_en_i,
  input wire logic pll_on_i,
  input wire logic aux_on_i,
  output logic osc_clk_o,
  output logic pll_clk_o,
  output logic aux_clk_o
);
  int cnt = 0;
  // osc well under clk/4; a stopped source sits flat, never free running
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (cnt % 4 == 3) begin
      osc_clk_o <= osc_en_i & ~osc_clk_o;
    end
    if (cnt % 2 == 1) begin
      pll_clk_o <= pll_on_i & ~pll_clk_o;
    end
    if (cnt % 6 == 5) begin
      aux_clk_o <= aux_on_i & ~aux_clk_o;
    end
  end
  initial begin
    osc_clk_o = 1'b0;
    pll_clk_o = 1'b0;
    aux_clk_o = 1'b0;
  end
endmodule
`default_nettype wire

// file: verif/cmu_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module cmu_top_tb_top;
  import cmu_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0, stb = 0, we = 0, wait_for_interrupt = 0, mwait = 0, breq = 0;
  logic hstop = 0, aux_on = 0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic ack, sysc, perc, cpuc, osc_en, pll_pw, irq_n, oscc, pllc, auxc;
  logic hre;
  logic [3:0] mult;
  int mismatches = 0;
  int num_checks = 0;
  logic [31:0] exp_q[$];

  cmu_top #(.AUX_TIMEOUT_CYC(16), .IRQ_LOW_CYC(4)) i_cmu_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .osc_clk_i(oscc),
    .pll_clk_i(pllc), .aux_clk_i(auxc), .hw_stop_i(hstop),
    .wfi_i(wait_for_interrupt), .mem_wait_i(mwait), .bus_req_i(breq),
    .sys_clk_o(sysc), .periph_clk_o(perc), .cpu_clk_o(cpuc),
    .osc_enable_o(osc_en), .pll_power_o(pll_pw), .pll_mult_o(mult),
    .halt_reset_en_o(hre), .irq_n_o(irq_n));

  cmu_src_model i_cmu_src_model (
    .clk_i(clk_i), .osc_en_i(osc_en), .pll_on_i(pll_pw),
    .aux_on_i(aux_on), .osc_clk_o(oscc), .pll_clk_o(pllc),
    .aux_clk_o(auxc));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    @(posedge clk_i iff ack);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, idx, 8'h00);
  endtask

  // read data is judged where the ack shows, against the oldest note
  always @(posedge clk_i) begin
    if (ack && cyc && !we) begin
      if (exp_q.size() == 0) begin
        chk(rdat, 32'hFFFF_FFFF);
      end else begin
        chk(rdat, exp_q.pop_front());
      end
    end
  end

  task automatic meas(input int n, output int s, output int c,
                      output int h, output int d);
    logic ps, pc;
    s = 0;
    c = 0;
    h = 0;
    d = 0;
    ps = sysc;
    pc = cpuc;
    repeat (n) begin
      @(negedge clk_i);
      s += int'(sysc & !ps);
      c += int'(cpuc & !pc);
      h += int'(cpuc);
      d += int'(perc !== sysc);
      ps = sysc;
      pc = cpuc;
    end
    @(posedge clk_i);
  endtask

  // bounded: a lost interrupt must not hang the run
  task automatic wait_irq(input int lim, output int lo);
    int t;
    t = 0;
    lo = 0;
    while (irq_n !== 1'b0 && t < lim) begin
      @(negedge clk_i);
      t++;
    end
    while (irq_n === 1'b0) begin
      @(negedge clk_i);
      lo++;
    end
    @(posedge clk_i);
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    int s, c, h, d, lo, p;
    logic [1:0] code;
    logic [3:0] fac[4];
    fac = '{MULT_10, MULT_6, MULT_14, MULT_8};
    p = $urandom(32'h7D9B);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_MODE, RST_MODE);
    rd(IDX_CTRL, RST_CTRL);
    rd(IDX_FLAG, RST_FLAG);
    rd(IDX_PLL, RST_PLL);
    chk(32'(pll_pw), 32'h0);
    rd(8'h10, 8'h00);
    for (int i = 0; i < 4; i++) begin
      code = 2'(i);
      wb(1'b1, IDX_PLL, {2'b00, code, 4'h1});
      repeat (4) @(negedge clk_i);
      chk(32'(mult), 32'(fac[i]));
      chk(32'(pll_pw), 32'h1);
    end
    repeat (200) @(posedge clk_i);
    wb(1'b1, IDX_FLAG, 8'h09);
    rd(IDX_FLAG, 8'h09);
    wb(1'b1, IDX_PLL, 8'h07);
    repeat (4) @(negedge clk_i);
    chk(32'(pll_pw), 32'h0);
    rd(IDX_FLAG, 8'h08);
    for (int k = 0; k < 2; k++) begin
      p = (k == 0) ? 0 : $urandom_range(7, 1);
      wb(1'b1, IDX_MODE, 8'(RST_MODE | (p << 2)));
      rd(IDX_MODE, 8'(RST_MODE | (p << 2)));
      repeat (40) @(posedge clk_i);
      meas(1600, s, c, h, d);
      chk(32'((c * (p + 1) - s) inside {[-(p + 1):p + 1]}), 1);
      chk(32'(d), 0);
    end
    chk(32'(h * 2 > 1600), 1);
    wb(1'b1, IDX_MODE, RST_MODE);
    for (int k = 0; k < 2; k++) begin
      mwait <= (k == 0);
      breq <= (k == 1);
      repeat (30) @(posedge clk_i);
      meas(400, s, c, h, d);
      chk(32'(h), 400);
    end
    mwait <= 1'b0;
    breq <= 1'b0;
    wait_for_interrupt <= 1'b1;
    repeat (30) @(posedge clk_i);
    meas(400, s, c, h, d);
    chk(32'(c), 0);
    chk(32'(s > 20), 1);
    wb(1'b1, IDX_PLL, 8'h01);
    wait_for_interrupt <= 1'b0;
    repeat (200) @(posedge clk_i);
    wb(1'b1, IDX_FLAG, 8'h09);
    wb(1'b1, IDX_CTRL, 8'h81);
    // watch from wfi entry on: the switch to slow16 may come at once
    wait_for_interrupt <= 1'b1;
    wait_irq(1500, lo);
    chk(32'(lo), 4);
    chk(32'(pll_pw), 0);
    rd(IDX_FLAG, 8'h08);
    meas(600, s, c, h, d);
    chk(32'(s inside {[2:3]}), 1);
    wait_for_interrupt <= 1'b0;
    wait_irq(1500, lo);
    chk(32'(lo), 4);
    wb(1'b1, IDX_CTRL, 8'h00);
    wb(1'b1, IDX_FLAG, 8'h00);
    wait_irq(1500, lo);
    chk(32'(lo), 0);
    wb(1'b1, IDX_CTRL, 8'h80);
    wb(1'b1, IDX_FLAG, 8'h08);
    wait_irq(1500, lo);
    chk(32'(lo), 4);
    hstop <= 1'b1;
    repeat (30) @(posedge clk_i);
    hstop <= 1'b0;
    wait_irq(300, lo);
    chk(32'(lo), 4);
    rd(IDX_FLAG, 8'h88);
    wb(1'b1, IDX_FLAG, 8'h18);
    rd(IDX_FLAG, 8'h08);
    chk(32'(osc_en), 1);
    wb(1'b1, IDX_CTRL, 8'h04);
    repeat (300) @(posedge clk_i);
    rd(IDX_FLAG, 8'h08);
    aux_on <= 1'b1;
    repeat (600) @(posedge clk_i);
    // crystal_stop was left set, so it shows and acts once aux is active
    rd(IDX_FLAG, 8'h1C);
    wb(1'b1, IDX_FLAG, 8'h1C);
    repeat (20) @(negedge clk_i);
    chk(32'(osc_en), 0);
    rd(IDX_FLAG, 8'h1C);
    wb(1'b1, IDX_CTRL, 8'h00);
    wb(1'b1, IDX_FLAG, 8'h08);
    repeat (300) @(posedge clk_i);
    rd(IDX_FLAG, 8'h08);
    chk(32'(osc_en), 1);
    wb(1'b1, IDX_CTRL, 8'h0B);
    wait_for_interrupt <= 1'b1;
    repeat (300) @(posedge clk_i);
    rd(IDX_FLAG, 8'h1C);
    rd(IDX_CTRL, 8'h0F);
    chk(32'(osc_en), 0);
    chk(32'(hre), 1);
    repeat (10) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
`default_nettype wire
